//--- logic/sync_serial_port.sv
// Synchronous serial port, master or slave, with its register file.
`timescale 1ns/1ps
`include "sync_serial_consts.svh"
module sync_serial_port
(
	input wire logic clock,
	input wire logic rst_b,
	input wire sync_serial_pkg::reg_addr_type addr,
	input wire sync_serial_pkg::reg_data_type wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output sync_serial_pkg::reg_data_type rdData,
	input wire logic clkIn,
	output logic clkOut,
	output logic clkOe_b,
	input wire logic dataIn,
	output logic dataOut,
	output logic dataOe_b,
	output logic rxIrq,
	output logic txIrq,
	output logic wakeRequest
);
	import sync_serial_pkg::*;

	link_state_type state_reg;
	logic portEn_reg;
	logic rx9_reg;
	logic single_receive_enable_reg;
	logic continuous_receive_enable_reg;
	logic overrun_error_flag_reg;
	logic receive_ninth_bit_reg;
	logic [7:0] rcBuf_reg;
	logic receive_complete_flag_reg;
	logic clock_source_select_reg;
	logic tx9_reg;
	logic transmit_enable_bit_reg;
	logic sync_reg;
	logic brgh_reg;
	logic transmit_ninth_bit_reg;
	logic [7:0] txBuf_reg;
	logic txBuf9_reg;
	logic txFull_reg;
	logic clock_polarity_select_reg;
	logic sixteen_bit_divisor_select_reg;
	logic [7:0] divHi_reg;
	logic [7:0] divLo_reg;
	logic receive_interrupt_enable_reg;
	logic transmit_interrupt_enable_reg;
	logic [8:0] tsr_reg;
	logic [8:0] rsr_reg;
	logic [3:0] bitCnt_reg;
	logic sclk_reg;
	logic clkS1_reg;
	logic clkS2_reg;
	logic clkS3_reg;
	logic dataS1_reg;
	logic dataS2_reg;
	logic [7:0] rdData_reg;

	logic portOn;
	logic master;
	logic fallEdge;
	logic slaveFall;
	logic rxWant;
	logic rxGo;
	logic loadTx;
	logic lastBit;
	logic wordDone;
	logic [3:0] frameBits;
	logic [8:0] newWord;
	logic wrRxStatus;
	logic wrTxBuffer;
	logic rdRxBuffer;

	shift_clock_if clkLink ();

	baud_tick_gen tickGen
	(
		.clock(clock),
		.rst_b(rst_b),
		.link(clkLink.gen)
	);

	assign portOn = portEn_reg && sync_reg;
	assign master = portOn && clock_source_select_reg;
	assign wrRxStatus = wrEn && (addr == `OFS_RX_STATUS);
	assign wrTxBuffer = wrEn && (addr == `OFS_TX_BUFFER);
	assign rdRxBuffer = rdEn && (addr == `OFS_RX_BUFFER);

	// The divisor uses the high byte only when the wide divisor is chosen.
	assign clkLink.divisor = sixteen_bit_divisor_select_reg ? {divHi_reg, divLo_reg}
		: {8'h00, divLo_reg};
	assign clkLink.run = master && (state_reg != LINK_IDLE);

	// Synchronisers for the pins before any logic sees them.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clkS1_reg <= 1'b0;
			clkS2_reg <= 1'b0;
			clkS3_reg <= 1'b0;
			dataS1_reg <= 1'b0;
			dataS2_reg <= 1'b0;
		end
		else
		begin
			clkS1_reg <= clkIn;
			clkS2_reg <= clkS1_reg;
			clkS3_reg <= clkS2_reg;
			dataS1_reg <= dataIn;
			dataS2_reg <= dataS1_reg;
		end
	end

	// The logical clock is the pin level with the idle polarity removed.
	assign slaveFall = (clkS3_reg ^ clock_polarity_select_reg) && !(clkS2_reg ^ clock_polarity_select_reg);
	assign fallEdge = master ? (clkLink.tick && sclk_reg) : slaveFall;

	// Master shift clock, idle low in logical terms.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			sclk_reg <= 1'b0;
		else if (!clkLink.run)
			sclk_reg <= 1'b0;
		else if (clkLink.tick)
			sclk_reg <= !sclk_reg;
	end

	assign frameBits = (state_reg == LINK_RX ? rx9_reg : tx9_reg)
		? `WORD_BITS_LONG : `WORD_BITS_SHORT;
	assign lastBit = fallEdge && (bitCnt_reg == frameBits - 4'h1);

	// Continuous enable decides alone when set; slave ignores single enable.
	assign rxWant = continuous_receive_enable_reg || (single_receive_enable_reg && master);
	// Transmit pending keeps the receiver off, and overrun stops it.
	assign loadTx = portOn && transmit_enable_bit_reg && txFull_reg
		&& (state_reg == LINK_IDLE);
	assign rxGo = portOn && rxWant && !overrun_error_flag_reg && !loadTx
		&& !(transmit_enable_bit_reg && txFull_reg) && (state_reg == LINK_IDLE);
	assign wordDone = (state_reg == LINK_RX) && lastBit;
	assign newWord = {dataS2_reg, rsr_reg[8:1]};

	// Link sequencer.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			state_reg <= LINK_IDLE;
		else
		begin
			case (state_reg)
				LINK_IDLE:
				begin
					if (loadTx)
						state_reg <= LINK_TX;
					else if (rxGo)
						state_reg <= LINK_RX;
				end
				LINK_TX:
				begin
					if (!portOn || lastBit)
						state_reg <= LINK_IDLE;
				end
				LINK_RX:
				begin
					if (!portOn || !rxWant || lastBit)
						state_reg <= LINK_IDLE;
				end
				default:
					state_reg <= LINK_IDLE;
			endcase
		end
	end

	// Bit counter for the word in flight.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			bitCnt_reg <= 4'h0;
		else if (state_reg == LINK_IDLE || lastBit)
			bitCnt_reg <= 4'h0;
		else if (fallEdge)
			bitCnt_reg <= bitCnt_reg + 4'h1;
	end

	// Transmit shift register, least significant bit first.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			tsr_reg <= 9'h000;
		else if (loadTx)
			tsr_reg <= {txBuf9_reg, txBuf_reg};
		else if (state_reg == LINK_TX && fallEdge)
			tsr_reg <= {1'b0, tsr_reg[8:1]};
	end

	// Receive shift register samples on each falling edge.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			rsr_reg <= 9'h000;
		else if (state_reg == LINK_RX && fallEdge)
			rsr_reg <= newWord;
	end

	// Transmit buffer; only a new write marks it full again.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			txBuf_reg <= `RESET_BYTE;
			txBuf9_reg <= 1'b0;
			txFull_reg <= 1'b0;
		end
		else if (wrTxBuffer)
		begin
			txBuf_reg <= wrData;
			txBuf9_reg <= tx9_reg && transmit_ninth_bit_reg;
			txFull_reg <= 1'b1;
		end
		else if (loadTx)
			txFull_reg <= 1'b0;
	end

	// Receive buffer and flags; a word with unread data pending is dropped.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rcBuf_reg <= `RESET_BYTE;
			receive_ninth_bit_reg <= 1'b0;
			receive_complete_flag_reg <= 1'b0;
		end
		else if (wordDone && !receive_complete_flag_reg)
		begin
			rcBuf_reg <= rx9_reg ? newWord[7:0] : newWord[8:1];
			receive_ninth_bit_reg <= rx9_reg && newWord[8];
			receive_complete_flag_reg <= 1'b1;
		end
		else if (rdRxBuffer)
			receive_complete_flag_reg <= 1'b0;
	end

	// Overrun sets on a word that finds the buffer full.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			overrun_error_flag_reg <= 1'b0;
		else if (wordDone && receive_complete_flag_reg)
			overrun_error_flag_reg <= 1'b1;
		else if (wrRxStatus && !wrData[`RX_CONT_BIT])
			overrun_error_flag_reg <= 1'b0;
	end

	// Receive status and control register.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			portEn_reg <= 1'b0;
			rx9_reg <= 1'b0;
			single_receive_enable_reg <= 1'b0;
			continuous_receive_enable_reg <= 1'b0;
		end
		else if (wrRxStatus)
		begin
			portEn_reg <= wrData[`RX_PORT_EN_BIT];
			rx9_reg <= wrData[`RX_NINE_BIT];
			single_receive_enable_reg <= wrData[`RX_SINGLE_BIT];
			continuous_receive_enable_reg <= wrData[`RX_CONT_BIT];
		end
		else if (wordDone && !continuous_receive_enable_reg)
			single_receive_enable_reg <= 1'b0;
	end

	// Transmit control, baud and interrupt enable registers.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clock_source_select_reg <= 1'b0;
			tx9_reg <= 1'b0;
			transmit_enable_bit_reg <= 1'b0;
			sync_reg <= 1'b0;
			brgh_reg <= 1'b0;
			transmit_ninth_bit_reg <= 1'b0;
			clock_polarity_select_reg <= 1'b0;
			sixteen_bit_divisor_select_reg <= 1'b0;
			divHi_reg <= `RESET_DIV;
			divLo_reg <= `RESET_DIV;
			receive_interrupt_enable_reg <= 1'b0;
			transmit_interrupt_enable_reg <= 1'b0;
		end
		else if (wrEn)
		begin
			case (addr)
				`OFS_TX_STATUS:
				begin
					clock_source_select_reg <= wrData[`TX_CLK_SRC_BIT];
					tx9_reg <= wrData[`TX_NINE_BIT];
					transmit_enable_bit_reg <= wrData[`TX_EN_BIT];
					sync_reg <= wrData[`TX_SYNC_BIT];
					brgh_reg <= wrData[`TX_HIGH_RATE_BIT];
					transmit_ninth_bit_reg <= wrData[`TX_NINTH_BIT];
				end
				`OFS_BAUD_CTRL:
				begin
					clock_polarity_select_reg <= wrData[`BAUD_POL_BIT];
					sixteen_bit_divisor_select_reg <= wrData[`BAUD_WIDE_BIT];
				end
				`OFS_DIV_HIGH:
					divHi_reg <= wrData;
				`OFS_DIV_LOW:
					divLo_reg <= wrData;
				`OFS_IRQ_CTRL:
				begin
					receive_interrupt_enable_reg <= wrData[`IRQ_RX_EN_BIT];
					transmit_interrupt_enable_reg <= wrData[`IRQ_TX_EN_BIT];
				end
				default:
				begin
				end
			endcase
		end
	end

	// Read data appear in the cycle after the read strobe.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			rdData_reg <= `RESET_BYTE;
		else if (rdEn)
		begin
			case (addr)
				`OFS_RX_STATUS:
					rdData_reg <= {portEn_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg,
						1'b0, 1'b0, overrun_error_flag_reg, receive_ninth_bit_reg};
				`OFS_RX_BUFFER:
					rdData_reg <= rcBuf_reg;
				`OFS_TX_STATUS:
					rdData_reg <= {clock_source_select_reg, tx9_reg, transmit_enable_bit_reg, sync_reg,
						1'b0, brgh_reg, state_reg != LINK_TX,
						transmit_ninth_bit_reg};
				`OFS_BAUD_CTRL:
					rdData_reg <= {1'b0, state_reg != LINK_RX, 1'b0,
						clock_polarity_select_reg, sixteen_bit_divisor_select_reg, 3'h0};
				`OFS_DIV_HIGH:
					rdData_reg <= divHi_reg;
				`OFS_DIV_LOW:
					rdData_reg <= divLo_reg;
				`OFS_TX_BUFFER:
					rdData_reg <= txBuf_reg;
				`OFS_IRQ_CTRL:
					rdData_reg <= {2'h0, receive_complete_flag_reg, !txFull_reg,
						2'h0, transmit_interrupt_enable_reg, receive_interrupt_enable_reg};
				default:
					rdData_reg <= `RESET_BYTE;
			endcase
		end
		else
			rdData_reg <= `RESET_BYTE;
	end

	assign rdData = rdData_reg;

	// Pins: the clock is driven only as master, data only while sending.
	assign clkOut = sclk_reg ^ clock_polarity_select_reg;
	assign clkOe_b = !master;
	assign dataOut = tsr_reg[0];
	assign dataOe_b = !(portOn && state_reg == LINK_TX);

	// Requests are levels that also wake a sleeping core.
	assign rxIrq = receive_complete_flag_reg && receive_interrupt_enable_reg;
	assign txIrq = !txFull_reg && transmit_interrupt_enable_reg;
	assign wakeRequest = rxIrq || txIrq;
endmodule

//--- logic/sync_serial_consts.svh
// Register offsets, field positions and reset values of the serial port.
`ifndef SYNC_SERIAL_CONSTS_SVH
`define SYNC_SERIAL_CONSTS_SVH
`define OFS_RX_STATUS 3'h0
`define OFS_RX_BUFFER 3'h1
`define OFS_TX_STATUS 3'h2
`define OFS_BAUD_CTRL 3'h3
`define OFS_DIV_HIGH 3'h4
`define OFS_DIV_LOW 3'h5
`define OFS_TX_BUFFER 3'h6
`define OFS_IRQ_CTRL 3'h7
`define RX_PORT_EN_BIT 7
`define RX_NINE_BIT 6
`define RX_SINGLE_BIT 5
`define RX_CONT_BIT 4
`define RX_FRAME_ERR_BIT 2
`define RX_OVERRUN_BIT 1
`define RX_NINTH_BIT 0
`define TX_CLK_SRC_BIT 7
`define TX_NINE_BIT 6
`define TX_EN_BIT 5
`define TX_SYNC_BIT 4
`define TX_HIGH_RATE_BIT 2
`define TX_EMPTY_BIT 1
`define TX_NINTH_BIT 0
`define BAUD_RX_IDLE_BIT 6
`define BAUD_POL_BIT 4
`define BAUD_WIDE_BIT 3
`define IRQ_RX_EN_BIT 0
`define IRQ_TX_EN_BIT 1
`define IRQ_TX_FLAG_BIT 4
`define IRQ_RX_FLAG_BIT 5
`define RESET_BYTE 8'h00
`define RESET_DIV 8'h00
`define WORD_BITS_SHORT 4'h8
`define WORD_BITS_LONG 4'h9
`endif

//--- logic/sync_serial_pkg.sv
// Types shared by the serial port modules.
package sync_serial_pkg;
	typedef logic [2:0] reg_addr_type;
	typedef logic [7:0] reg_data_type;
	typedef enum logic [2:0]
	{
		LINK_IDLE = 3'b001,
		LINK_TX = 3'b010,
		LINK_RX = 3'b100
	} link_state_type;
endpackage

//--- logic/shift_clock_if.sv
// Connection between the port logic and its shift clock generator.
`timescale 1ns/1ps
interface shift_clock_if;
	logic run;
	logic [15:0] divisor;
	logic tick;
	modport gen (input run, input divisor, output tick);
	modport user (output run, output divisor, input tick);
endinterface

//--- logic/baud_tick_gen.sv
// Half-period tick generator for the master shift clock.
`timescale 1ns/1ps
module baud_tick_gen
(
	input wire logic clock,
	input wire logic rst_b,
	shift_clock_if.gen link
);
	logic [16:0] count_reg;
	logic [16:0] limit;

	// Each half period lasts two clocks per divisor step, plus two.
	assign limit = {link.divisor, 1'b1};
	assign link.tick = link.run && (count_reg == limit);

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			count_reg <= 17'h00000;
		else if (!link.run || link.tick)
			count_reg <= 17'h00000;
		else
			count_reg <= count_reg + 17'h00001;
	end
endmodule

//--- bench/sync_serial_chk.sv
// Assertions on the serial port's strobes, requests and pin enables.
`timescale 1ns/1ps
module sync_serial_chk
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire sync_serial_pkg::reg_data_type rdData,
	input wire logic clkOe_b,
	input wire logic dataOe_b,
	input wire logic rxIrq,
	input wire logic txIrq,
	input wire logic wakeRequest
);
	import sync_serial_pkg::*;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence wordBegins;
		$fell(dataOe_b);
	endsequence
	sequence wordShifts;
		!dataOe_b [*8];
	endsequence
	read_quiet_a: assert property (!rdEn |=> rdData == 8'h00)
		else $error("read data outside a read");
	wake_join_a: assert property (wakeRequest == (rxIrq | txIrq))
		else $error("wake request wrong");
	tx_flag_a: assert property ($fell(txIrq) |-> $past(wrEn))
		else $error("transmit request fell alone");
	rx_flag_a: assert property ($fell(rxIrq) |-> $past(rdEn | wrEn))
		else $error("receive request fell alone");
	clock_drive_a: assert property
		($fell(clkOe_b) |-> $past(wrEn) | $past(wrEn, 2))
		else $error("clock pin driven alone");
	word_start_a: assert property
		(wordBegins |-> $past(wrEn) | $past(wrEn, 2) | rxIrq
		| !$past(dataOe_b, 2) | !$past(dataOe_b, 3))
		else $error("word started alone");
	word_length_a: assert property (wordBegins |-> wordShifts)
		else $error("word too short");
	half_duplex_a: assert property
		($rose(rxIrq) && !$past(wrEn) |-> dataOe_b)
		else $error("word received while sending");
endmodule
bind sync_serial_port sync_serial_chk sync_serial_chk_inst
(
	.clock(clock),
	.rst_b(rst_b),
	.wrEn(wrEn),
	.rdEn(rdEn),
	.rdData(rdData),
	.clkOe_b(clkOe_b),
	.dataOe_b(dataOe_b),
	.rxIrq(rxIrq),
	.txIrq(txIrq),
	.wakeRequest(wakeRequest)
);

//--- bench/link_partner.sv
// Far-side device: makes the slave clock, feeds and captures data bits.
`timescale 1ns/1ps
module link_partner
(
	input wire logic clkPin,
	input wire logic dataPin,
	output logic clkDrive,
	output logic dataDrive
);
	logic [7:0] sendWord = 8'h00;
	logic [7:0] seen = 8'h00;
	logic [7:0] words[$];
	int bitIdx = 0;
	initial
	begin
		clkDrive = 1'b0;
		dataDrive = 1'b0;
	end
	// Data moves on the rising edge so it is settled at the falling one.
	always @(posedge clkPin)
	begin
		seen <= {dataPin, seen[7:1]};
		if (bitIdx % 8 == 7)
			words.push_back({dataPin, seen[7:1]});
		dataDrive <= sendWord[bitIdx % 8];
		bitIdx <= bitIdx + 1;
	end
	// The clock stays low between frames.
	task automatic pulses(input int n);
		repeat (n)
		begin
			#62.5 clkDrive = 1'b1;
			#62.5 clkDrive = 1'b0;
		end
	endtask
endmodule

//--- bench/sync_serial_port_master_slave_bench.sv
// Bench for the serial port: registers, master and slave transfers.
`timescale 1ns/1ps
`include "sync_serial_consts.svh"
module sync_serial_port_master_slave_bench;
	import sync_serial_pkg::*;
	logic clock;
	logic rst_b;
	reg_addr_type addr;
	reg_data_type wrData;
	logic wrEn;
	logic rdEn;
	reg_data_type rdData;
	logic clkOut;
	logic clkOe_b;
	logic dataOut;
	logic dataOe_b;
	logic rxIrq;
	logic txIrq;
	logic wakeRequest;
	logic clkDrive;
	logic dataDrive;
	wire logic clkPin;
	wire logic dataPin;
	int nErrors;
	int testsRun;
	reg_data_type got;
	assign clkPin = clkOe_b ? clkDrive : clkOut;
	assign dataPin = dataOe_b ? dataDrive : dataOut;
	sync_serial_port sync_serial_port_inst
	(
		.clock(clock),
		.rst_b(rst_b),
		.addr(addr),
		.wrData(wrData),
		.wrEn(wrEn),
		.rdEn(rdEn),
		.rdData(rdData),
		.clkIn(clkPin),
		.clkOut(clkOut),
		.clkOe_b(clkOe_b),
		.dataIn(dataPin),
		.dataOut(dataOut),
		.dataOe_b(dataOe_b),
		.rxIrq(rxIrq),
		.txIrq(txIrq),
		.wakeRequest(wakeRequest)
	);
	link_partner link_partner_inst
	(
		.clkPin(clkPin),
		.dataPin(dataPin),
		.clkDrive(clkDrive),
		.dataDrive(dataDrive)
	);
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic check(input string what, input reg_data_type seen,
		input reg_data_type exp);
		testsRun++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input reg_addr_type a, input reg_data_type d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge clock);
		wrEn <= 1'b0;
	endtask
	task automatic rd(input reg_addr_type a);
		@(posedge clock);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clock);
		rdEn <= 1'b0;
		#1;
		got = rdData;
	endtask
	task automatic slaveWord(input reg_data_type w);
		link_partner_inst.sendWord = w;
		link_partner_inst.bitIdx = 0;
		link_partner_inst.pulses(8);
		repeat (8) @(posedge clock);
	endtask
	task automatic regsAfterReset();
		rd(`OFS_TX_STATUS);
		check("shift empty", got, 8'h02);
		wr(`OFS_IRQ_CTRL, 8'h30);
		rd(`OFS_IRQ_CTRL);
		check("flags read only", got, 8'h10);
		wr(`OFS_DIV_LOW, 8'h03);
		rd(`OFS_DIV_LOW);
		check("divisor", got, 8'h03);
	endtask
	task automatic masterTx();
		wr(`OFS_RX_STATUS, 8'h80);
		wr(`OFS_TX_STATUS, 8'hB0);
		wr(`OFS_IRQ_CTRL, 8'h02);
		wr(`OFS_TX_BUFFER, 8'h3C);
		wr(`OFS_TX_BUFFER, 8'hC5);
		#1;
		check("flag held", {7'h00, txIrq}, 8'h00);
		// Outputs are looked at 1 ns after the edge, once they have settled.
		for (int i = 0; i < 900 && !txIrq; i++)
		begin
			@(posedge clock);
			#1;
		end
		check("flag set", {7'h00, txIrq}, 8'h01);
		check("word one", link_partner_inst.words[0], 8'h3C);
		for (int i = 0; i < 900 && !dataOe_b; i++)
		begin
			@(posedge clock);
			#1;
		end
		check("word two", link_partner_inst.words[1], 8'hC5);
		rd(`OFS_TX_STATUS);
		check("shift done", got, 8'hB2);
		wr(`OFS_TX_STATUS, 8'h90);
	endtask
	task automatic masterRx();
		link_partner_inst.sendWord = 8'h96;
		link_partner_inst.bitIdx = 0;
		wr(`OFS_IRQ_CTRL, 8'h01);
		wr(`OFS_RX_STATUS, 8'hA0);
		for (int i = 0; i < 900 && !rxIrq; i++)
		begin
			@(posedge clock);
			#1;
		end
		check("rx flag", {7'h00, rxIrq}, 8'h01);
		rd(`OFS_RX_STATUS);
		check("single done", got, 8'h80);
		rd(`OFS_RX_BUFFER);
		check("rx word", got, 8'h96);
		repeat (300) @(posedge clock);
		check("one word only", {7'h00, rxIrq}, 8'h00);
	endtask
	task automatic slaveRx();
		wr(`OFS_TX_STATUS, 8'h10);
		wr(`OFS_RX_STATUS, 8'hA0);
		slaveWord(8'h5A);
		check("single ignored", {7'h00, rxIrq}, 8'h00);
		wr(`OFS_RX_STATUS, 8'h90);
		slaveWord(8'h5A);
		check("slave word", {7'h00, rxIrq}, 8'h01);
		slaveWord(8'h33);
		rd(`OFS_RX_STATUS);
		check("overrun", got, 8'h92);
		rd(`OFS_RX_BUFFER);
		check("kept word", got, 8'h5A);
		wr(`OFS_RX_STATUS, 8'h80);
		rd(`OFS_RX_STATUS);
		check("error cleared", got, 8'h80);
	endtask
	task automatic slaveTx();
		wr(`OFS_TX_STATUS, 8'h71);
		wr(`OFS_TX_BUFFER, 8'hA5);
		link_partner_inst.pulses(8);
		check("slave tx byte", link_partner_inst.seen, 8'hA5);
		link_partner_inst.pulses(1);
		check("slave ninth", link_partner_inst.seen, 8'hD2);
		repeat (8) @(posedge clock);
		rd(`OFS_TX_STATUS);
		check("slave shift done", got, 8'h73);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		rst_b = 1'b0;
		addr = 3'h0;
		wrData = 8'h00;
		wrEn = 1'b0;
		rdEn = 1'b0;
		nErrors = 0;
		testsRun = 0;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		regsAfterReset();
		masterTx();
		masterRx();
		slaveRx();
		slaveTx();
		results();
	end
	initial
	begin
		#200000;
		nErrors++;
		results();
	end
endmodule
